// ### logic/afp_pkg.sv
// shared constants and carriers for the async byte fifo port
package afp_pkg;

    // data path
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned TX_DEPTH = 4;

    // timing: clock rate and the least wake-up low time
    localparam int unsigned CLK_KHZ     = 40000;
    localparam int unsigned WAKE_MIN_MS = 20;
    localparam int unsigned WAKE_CYCLES = WAKE_MIN_MS * CLK_KHZ;

    // pin sample carrier, synchronised as one word
    typedef struct packed {
        logic              rd_n;
        logic              wr;
        logic              rxf_n;
        logic [DATA_W-1:0] data;
    } afp_pins_t;

    // reset values
    localparam afp_pins_t PINS_IDLE   = '{rd_n: 1'b1, wr: 1'b0, rxf_n: 1'b1, data: 8'h00};
    localparam logic      RST_OE_N    = 1'b1;
    localparam logic      RST_FLAG_N  = 1'b1;
    localparam logic      RST_POWER_ENABLE_N_N = 1'b0;
    localparam logic      RST_PULL_HI = 1'b1;

endpackage

// ### logic/afp_fifo.sv
`timescale 1ns/100ps
// small fifo in the transmit path, full and empty kept as state
module afp_fifo #(
    parameter int unsigned W     = 8,
    parameter int unsigned DEPTH = 4
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    // filling side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // draining side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    full;
        logic                    empty;
    } afp_fifo_st_t;

    afp_fifo_st_t st_ff;
    afp_fifo_st_t nxt_st;
    logic         push;
    logic         pop;

    // flags are flops, so the ready seen outside is never a long path
    always_comb begin
        nxt_st = st_ff;
        push   = in_valid_i && !st_ff.full;
        pop    = out_ready_i && !st_ff.empty;
        if (push) begin
            nxt_st.mem[st_ff.wp] = in_data_i;
            nxt_st.wp = (st_ff.wp == AW'(DEPTH - 1)) ? '0 : st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = (st_ff.rp == AW'(DEPTH - 1)) ? '0 : st_ff.rp + 1'b1;
        end
        if (push && !pop) nxt_st.cnt = st_ff.cnt + 1'b1;
        if (pop && !push) nxt_st.cnt = st_ff.cnt - 1'b1;
        nxt_st.full  = (nxt_st.cnt == CW'(DEPTH));
        nxt_st.empty = (nxt_st.cnt == '0);
        if (sys_rst_i) begin
            nxt_st       = '0;
            nxt_st.empty = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_ff <= nxt_st;
    end

    assign in_ready_o  = !st_ff.full;
    assign out_valid_o = !st_ff.empty;
    assign out_data_o  = st_ff.mem[st_ff.rp];
endmodule

// ### logic/afp_wake.sv
`timescale 1ns/100ps
// measures a low on the wake pin and asks for resume once per low period
module afp_wake #(
    parameter int unsigned CYC = afp_pkg::WAKE_CYCLES
) (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    // wake pin, already synchronised, and its enable
    input  wire logic arm_i,
    input  wire logic level_n_i,
    // one-cycle request towards the usb side
    output logic      resume_o
);
    localparam int unsigned CW = $clog2(CYC + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          fired;
        logic          resume;
    } afp_wake_st_t;

    afp_wake_st_t  st_ff;
    afp_wake_st_t  nxt_st;
    logic [CW-1:0] low_run_ff;

    // a release or disarm restarts the count, so glitches never add up
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.resume = 1'b0;
        if (!arm_i || level_n_i) begin
            nxt_st.cnt   = '0;
            nxt_st.fired = 1'b0;
        end else if (!st_ff.fired) begin
            if (st_ff.cnt == CW'(CYC - 1)) begin
                nxt_st.resume = 1'b1;
                nxt_st.fired  = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
        if (sys_rst_i) nxt_st = '0;
    end

    always_ff @(posedge mclk_i) begin
        st_ff <= nxt_st;
    end

    assign resume_o = st_ff.resume;

    // helper: length of the present armed low run, saturating
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i || !arm_i || level_n_i) begin
            low_run_ff <= '0;
        end else if (low_run_ff != CW'(CYC)) begin
            low_run_ff <= low_run_ff + 1'b1;
        end
    end

    a_resume_min_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        resume_o |-> $past(low_run_ff) == CW'(CYC - 1))
        else $error("resume requested without the full low time");
endmodule

// ### logic/afp_port.sv
`timescale 1ns/100ps
module afp_port #(
    parameter int unsigned WAKE_CYCLES = afp_pkg::WAKE_CYCLES,
    parameter int unsigned TX_DEPTH    = afp_pkg::TX_DEPTH
) (
    // clock and reset
    input  wire logic                       mclk_i,
    input  wire logic                       sys_rst_i,
    // strobes from the controller
    input  wire logic                       rd_n_i,
    input  wire logic                       wr_i,
    // data bus, split into in, out and enable
    input  wire logic [afp_pkg::DATA_W-1:0] fifo_data_bus_i,
    output logic      [afp_pkg::DATA_W-1:0] fifo_data_bus_o,
    output logic                            fifo_data_bus_oe_n_o,
    // pacing flags
    output logic                            tx_space_flag_n_o,
    output logic                            tx_space_flag_oe_n_o,
    input  wire logic                       rx_data_flag_n_i,
    output logic                            rx_data_flag_n_o,
    output logic                            rx_data_flag_oe_n_o,
    // suspend indication and pin pulls
    output logic                            power_enable_n_o,
    output logic                            pin_pull_low_o,
    output logic                            pin_pull_high_o,
    // usb side control and configuration memory options
    input  wire logic                       usb_suspend_i,
    input  wire logic                       cfg_remote_wakeup_i,
    input  wire logic                       cfg_suspend_pull_low_i,
    output logic                            resume_req_o,
    // receive stream from the usb side
    input  wire logic                       rx_valid_i,
    input  wire logic [afp_pkg::DATA_W-1:0] rx_data_i,
    output logic                            rx_ready_o,
    // transmit stream to the usb side
    output logic                            tx_valid_o,
    output logic      [afp_pkg::DATA_W-1:0] tx_data_o,
    input  wire logic                       tx_ready_i
);
    typedef struct packed {
        afp_pkg::afp_pins_t          s1;
        afp_pkg::afp_pins_t          s2;
        logic                        rd_d;
        logic                        wr_d;
        logic [afp_pkg::DATA_W-1:0]  cur;
        logic                        cur_v;
        logic                        rx_rdy;
        logic [afp_pkg::DATA_W-1:0]  dout;
        logic                        dout_oe_n;
        logic                        txf_n;
        logic                        txf_oe_n;
        logic                        rxf_n;
        logic                        rxf_oe_n;
        logic                        power_enable_n_n;
        logic                        pull_lo;
        logic                        pull_hi;
        logic [afp_pkg::DATA_W-1:0]  txd;
        logic                        txv;
    } afp_port_st_t;

    afp_port_st_t               st_ff;
    afp_port_st_t               nxt_st;
    afp_pkg::afp_pins_t         pins_raw;
    logic                       rd_fall;
    logic                       wr_fall;
    logic                       push;
    logic                       wake_arm;
    logic                       fifo_in_ready;
    logic                       fifo_out_valid;
    logic [afp_pkg::DATA_W-1:0] fifo_out_data;
    logic                       fifo_pop;
    logic                       resume_pulse;

    // high-to-low edge on a synchronised strobe
    function automatic logic fell(input logic prev, input logic now);
        return prev && !now;
    endfunction

    // all pins sampled as one word so data and strobe stay aligned
    assign pins_raw = '{rd_n: rd_n_i, wr: wr_i, rxf_n: rx_data_flag_n_i, data: fifo_data_bus_i};

    // edges are taken from the second stage only, never the first
    assign rd_fall  = fell(st_ff.rd_d, st_ff.s2.rd_n);
    assign wr_fall  = fell(st_ff.wr_d, st_ff.s2.wr);
    // a write while we drive the bus would capture our own byte
    assign push     = wr_fall && st_ff.s2.rd_n;
    assign wake_arm = st_ff.power_enable_n_n && cfg_remote_wakeup_i;
    assign fifo_pop = fifo_out_valid && (!st_ff.txv || tx_ready_i);

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pins_raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.rd_d = st_ff.s2.rd_n;
        nxt_st.wr_d = st_ff.s2.wr;

        // read side: falling edge hands the waiting byte to the bus latch
        if (rd_fall && st_ff.cur_v) begin
            nxt_st.dout  = st_ff.cur;
            nxt_st.cur_v = 1'b0;
        end
        if (st_ff.rx_rdy && rx_valid_i) begin
            nxt_st.cur   = rx_data_i;
            nxt_st.cur_v = 1'b1;
        end
        // one holding slot keeps the flag exact; some throughput is traded for it
        nxt_st.rx_rdy = !nxt_st.cur_v;

        // bus driven only while the strobe is low
        nxt_st.dout_oe_n = st_ff.s2.rd_n;

        // receive flag follows the holding byte
        nxt_st.rxf_n = !nxt_st.cur_v;

        // flag held high for the write cycle itself, fifo count lags one
        nxt_st.txf_n = !fifo_in_ready || push;

        // wake mode hands the receive flag pin to the outside
        nxt_st.txf_oe_n = 1'b0;
        nxt_st.rxf_oe_n = wake_arm;

        // suspend indication and pin pulls
        nxt_st.power_enable_n_n = usb_suspend_i;
        nxt_st.pull_lo = usb_suspend_i && cfg_suspend_pull_low_i;
        nxt_st.pull_hi = !(usb_suspend_i && cfg_suspend_pull_low_i);

        // output stage after the fifo, so the stream comes from flops
        if (fifo_pop) begin
            nxt_st.txd = fifo_out_data;
            nxt_st.txv = 1'b1;
        end else if (tx_ready_i) begin
            nxt_st.txv = 1'b0;
        end

        // reset floats both flags and the bus
        if (sys_rst_i) begin
            nxt_st           = '0;
            nxt_st.s1        = afp_pkg::PINS_IDLE;
            nxt_st.s2        = afp_pkg::PINS_IDLE;
            nxt_st.rd_d      = afp_pkg::PINS_IDLE.rd_n;
            nxt_st.rx_rdy    = 1'b1;
            nxt_st.dout_oe_n = afp_pkg::RST_OE_N;
            nxt_st.txf_oe_n  = afp_pkg::RST_OE_N;
            nxt_st.rxf_oe_n  = afp_pkg::RST_OE_N;
            nxt_st.txf_n     = afp_pkg::RST_FLAG_N;
            nxt_st.rxf_n     = afp_pkg::RST_FLAG_N;
            nxt_st.power_enable_n_n   = afp_pkg::RST_POWER_ENABLE_N_N;
            nxt_st.pull_hi   = afp_pkg::RST_PULL_HI;
        end
    end

    always_ff @(posedge mclk_i) begin
        st_ff <= nxt_st;
    end

    // transmit buffer, full flag paces the controller
    afp_fifo #(
        .W     (afp_pkg::DATA_W),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (push),
        .in_data_i   (st_ff.s2.data),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    // wake-up low time measurement on the receive flag pin
    afp_wake #(
        .CYC (WAKE_CYCLES)
    ) u_wake (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .arm_i     (wake_arm),
        .level_n_i (st_ff.s2.rxf_n),
        .resume_o  (resume_pulse)
    );

    // outputs straight from flops
    assign fifo_data_bus_o      = st_ff.dout;
    assign fifo_data_bus_oe_n_o = st_ff.dout_oe_n;
    assign tx_space_flag_n_o    = st_ff.txf_n;
    assign tx_space_flag_oe_n_o = st_ff.txf_oe_n;
    assign rx_data_flag_n_o     = st_ff.rxf_n;
    assign rx_data_flag_oe_n_o  = st_ff.rxf_oe_n;
    assign power_enable_n_o     = st_ff.power_enable_n_n;
    assign pin_pull_low_o       = st_ff.pull_lo;
    assign pin_pull_high_o      = st_ff.pull_hi;
    assign resume_req_o         = resume_pulse;
    assign rx_ready_o           = st_ff.rx_rdy;
    assign tx_valid_o           = st_ff.txv;
    assign tx_data_o            = st_ff.txd;

    // checks on the pin behaviour
    default clocking afp_cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_bus_driven_low: assert property (
        !st_ff.s2.rd_n ##1 !st_ff.s2.rd_n |-> !fifo_data_bus_oe_n_o)
        else $error("bus not driven while read strobe low");

    a_read_next_byte: assert property (
        rd_fall && st_ff.cur_v |=> fifo_data_bus_o == $past(st_ff.cur) && rx_ready_o)
        else $error("read edge did not advance the receive byte");

    property p_write_lands;
        logic [afp_pkg::DATA_W-1:0] d;
        (push && !fifo_out_valid && !st_ff.txv, d = st_ff.s2.data) |-> ##2 (tx_valid_o && tx_data_o == d);
    endproperty
    a_write_capture: assert property (p_write_lands)
        else $error("written byte did not reach the transmit stream");

    a_tx_full_flag: assert property (
        !fifo_in_ready |=> tx_space_flag_n_o)
        else $error("space flag low while buffer full");

    a_reset_floats: assert property (disable iff (1'b0)
        sys_rst_i |=> tx_space_flag_oe_n_o && rx_data_flag_oe_n_o && fifo_data_bus_oe_n_o)
        else $error("flag pins driven during reset");

    a_rx_flag_data: assert property (
        rx_valid_i && rx_ready_o |=> !rx_data_flag_n_o ##1 (rx_data_flag_n_o == !st_ff.cur_v))
        else $error("receive flag does not follow waiting byte");

    a_wake_pin_input: assert property (
        power_enable_n_o && cfg_remote_wakeup_i |=> rx_data_flag_oe_n_o)
        else $error("receive flag still driven in wake mode");

    a_suspend_pull: assert property (
        usb_suspend_i && cfg_suspend_pull_low_i |=> pin_pull_low_o && !pin_pull_high_o)
        else $error("pins not pulled low in suspend");

    a_power_enable: assert property (
        1'b1 |=> power_enable_n_o == $past(usb_suspend_i))
        else $error("power enable does not show suspend");

    a_bus_released: assert property (
        st_ff.s2.rd_n |=> fifo_data_bus_oe_n_o)
        else $error("bus driven while read strobe high");

    // pacing checks in both directions; a flag that lies loses bytes
    a_tx_flag_write: assert property (
        push |=> tx_space_flag_n_o)
        else $error("space flag low right after an accepted write");

    a_tx_flag_room: assert property (
        fifo_in_ready && !push |=> !tx_space_flag_n_o)
        else $error("space flag high while the buffer has room");

    a_tx_flag_driven: assert property (
        1'b1 |=> !tx_space_flag_oe_n_o)
        else $error("space flag left floating out of reset");

    a_rx_flag_read: assert property (
        rd_fall && st_ff.cur_v |=> rx_data_flag_n_o)
        else $error("receive flag low after the last byte was read");

    a_rx_flag_ready: assert property (
        rx_ready_o == rx_data_flag_n_o)
        else $error("receive flag and stream ready disagree");

    // a read with nothing waiting must leave the old byte on the bus
    a_read_refused: assert property (
        rd_fall && !st_ff.cur_v |=> $stable(fifo_data_bus_o))
        else $error("empty read changed the bus byte");

    // the usb side may stall; the offered byte must not move meanwhile
    a_tx_stream_hold: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("transmit stream changed while stalled");

    a_pull_one_hot: assert property (
        pin_pull_low_o != pin_pull_high_o)
        else $error("pin pulls both on or both off");

    a_resume_armed: assert property (
        resume_req_o |-> $past(wake_arm))
        else $error("resume requested outside wake mode");

    // main scenarios
    c_read_byte: cover property (rd_fall && st_ff.cur_v);
    c_write_byte: cover property (push && fifo_in_ready);
    c_tx_full: cover property (!fifo_in_ready ##1 tx_space_flag_n_o);
    c_wake_resume: cover property (resume_req_o);
    c_empty_read: cover property (rd_fall && !st_ff.cur_v);
endmodule

// ### tb/afp_host.sv
`timescale 1ns/100ps
// controller model on the pins; it never reads the flags faster than a real one could
module afp_host (
    // bench clock, only to pace strobes
    input  wire logic       mclk_i,
    // pin levels as resolved on the board
    input  wire logic [7:0] bus_i,
    input  wire logic       txf_n_i,
    input  wire logic       rxf_n_i,
    // strobes and data it drives
    output logic            rd_n_o,
    output logic            wr_o,
    output logic [7:0]      dat_o,
    output logic            dat_en_o,
    // each byte read, and a lost wait
    output logic            rd_done_o,
    output logic [7:0]      rd_byte_o,
    output logic            to_o
);
    // idle pins at time zero
    initial begin
        rd_n_o = 1'b1;
        wr_o = 1'b0;
        dat_o = 8'h00;
        dat_en_o = 1'b0;
        rd_done_o = 1'b0;
        rd_byte_o = 8'h00;
        to_o = 1'b0;
    end

    // bounded wait for a low flag; a floating flag reads high and never lets us through
    task automatic wait_flag(input bit rx);
        int n;
        n = 0;
        while ((rx ? rxf_n_i : txf_n_i) !== 1'b0 && n < 400) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        if (n >= 400) to_o = 1'b1;
    endtask

    // one read: strobe low, take the byte late in the low phase, strobe high again
    task automatic read_byte(input int hold, input bit obey);
        if (obey) wait_flag(1'b1);
        rd_n_o = 1'b0;
        repeat (hold) @(posedge mclk_i);
        rd_byte_o = bus_i;
        #1;
        rd_n_o = 1'b1;
        rd_done_o = 1'b1;
        repeat (hold) @(posedge mclk_i);
        #1;
        rd_done_o = 1'b0;
    endtask

    // one write: data and strobe high together, strobe low, data held after the fall
    task automatic write_byte(input logic [7:0] b, input int hold);
        wait_flag(1'b0);
        dat_o = b;
        dat_en_o = 1'b1;
        wr_o = 1'b1;
        repeat (hold) @(posedge mclk_i);
        #1;
        wr_o = 1'b0;
        repeat (hold) @(posedge mclk_i);
        #1;
        dat_en_o = 1'b0;
        // let an edge pass so the next write never re-drives in this step
        @(posedge mclk_i);
        #1;
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/100ps
// bench plays the usb side; the host model works the pins
module testbench;
    localparam int unsigned WAKE = 16;
    logic       mclk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       rx_valid_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic       tx_ready_i = 1'b0;
    logic       usb_suspend_i = 1'b0;
    logic       cfg_rw = 1'b0;
    logic       cfg_pl = 1'b0;
    logic       wake_low = 1'b0;
    logic       tx_go = 1'b0;
    logic [7:0] bus_o, tx_data_o, h_dat, rd_byte, bus_pin, b;
    logic       bus_oe_n, txf_n, txf_oe_n, rxf_n, rxf_oe_n, power_enable_n_n, pull_lo, pull_hi;
    logic       resume_req_o, rx_ready_o, tx_valid_o, rd_n, wr, h_en, rd_done, to;
    logic       txf_pin, rxf_pin;
    logic [7:0] tx_q[$];
    logic [7:0] rd_q[$];
    int         fails = 0;
    int         cmp_count = 0;
    int         resumes = 0;
    int         n;

    // pin levels from all drivers; undriven pins follow the enabled pull
    assign bus_pin = !bus_oe_n ? bus_o : h_en ? h_dat : {8{pull_hi}};
    assign txf_pin = !txf_oe_n ? txf_n : pull_hi;
    assign rxf_pin = !rxf_oe_n ? rxf_n : (wake_low ? 1'b0 : pull_hi);

    afp_port #(.WAKE_CYCLES(WAKE), .TX_DEPTH(4)) i_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .rd_n_i(rd_n), .wr_i(wr),
        .fifo_data_bus_i(bus_pin), .fifo_data_bus_o(bus_o), .fifo_data_bus_oe_n_o(bus_oe_n),
        .tx_space_flag_n_o(txf_n), .tx_space_flag_oe_n_o(txf_oe_n), .rx_data_flag_n_i(rxf_pin),
        .rx_data_flag_n_o(rxf_n), .rx_data_flag_oe_n_o(rxf_oe_n), .power_enable_n_o(power_enable_n_n),
        .pin_pull_low_o(pull_lo), .pin_pull_high_o(pull_hi), .usb_suspend_i(usb_suspend_i),
        .cfg_remote_wakeup_i(cfg_rw), .cfg_suspend_pull_low_i(cfg_pl), .resume_req_o(resume_req_o),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));

    afp_host i_host (
        .mclk_i(mclk_i), .bus_i(bus_pin), .txf_n_i(txf_pin), .rxf_n_i(rxf_pin), .rd_n_o(rd_n),
        .wr_o(wr), .dat_o(h_dat), .dat_en_o(h_en), .rd_done_o(rd_done), .rd_byte_o(rd_byte), .to_o(to));

    // 40 MHz
    always #12.5 mclk_i = ~mclk_i;

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    // offer one byte from the usb side, held until taken
    task automatic push_rx(input logic [7:0] d);
        logic ok;
        rx_valid_i = 1'b1;
        rx_data_i = d;
        n = 0;
        do begin
            ok = rx_ready_o;
            tick(1);
            n++;
        end while (ok !== 1'b1 && n < 300);
        rx_valid_i = 1'b0;
        tick(1);
        if (n >= 300) begin
            fails++;
            stop_test();
        end
    endtask

    // usb side drains with random stalls so the fifo sees back pressure
    always @(posedge mclk_i) begin
        #1;
        tx_ready_i = tx_go & 1'($urandom_range(1, 0));
    end

    // watchers: oldest note against each result as it appears
    always @(posedge mclk_i) begin
        if (tx_valid_o === 1'b1 && tx_ready_i) cmp("tx byte", tx_q.size() ? tx_q.pop_front() : 8'hxx, tx_data_o);
        if (resume_req_o === 1'b1) resumes++;
    end
    always @(posedge rd_done) cmp("read byte", rd_q.size() ? rd_q.pop_front() : 8'hxx, rd_byte);

    // a lost handshake ends the run
    always @(posedge to) begin
        fails++;
        stop_test();
    end

    initial begin
        n = $urandom(32'h5efd);
        repeat (8) @(posedge mclk_i);
        #1;
        cmp("flag enables in reset", 8'h03, {6'h00, txf_oe_n, rxf_oe_n});
        cmp("bus enable in reset", 8'h01, {7'h00, bus_oe_n});
        sys_rst_i = 1'b0;
        tick(3);
        cmp("flags after reset", 8'h01, {4'h0, txf_oe_n, rxf_oe_n, txf_n, rxf_n});
        $display("reset test done");

        // receive: one byte first, then reads racing further bytes, then a read with nothing waiting
        b = 8'($urandom);
        rd_q.push_back(b);
        push_rx(b);
        tick(4);
        cmp("rx flag with byte", 8'h00, {7'h00, rxf_n});
        fork
            repeat (5) begin
                b = 8'($urandom);
                rd_q.push_back(b);
                push_rx(b);
            end
            repeat (6) i_host.read_byte($urandom_range(8, 6), 1'b1);
        join
        tick(4);
        cmp("rx flag when empty", 8'h01, {7'h00, rxf_n});
        rd_q.push_back(b);
        i_host.read_byte(6, 1'b0);
        tick(3);
        cmp("bus enable strobe high", 8'h01, {7'h00, bus_oe_n});
        $display("read test done");

        // transmit: fill while stalled until the flag holds high, then drain
        repeat (5) begin
            b = 8'($urandom);
            tx_q.push_back(b);
            i_host.write_byte(b, $urandom_range(8, 5));
        end
        tick(6);
        cmp("tx flag when full", 8'h01, {7'h00, txf_n});
        tx_go = 1'b1;
        repeat (6) begin
            b = 8'($urandom);
            tx_q.push_back(b);
            i_host.write_byte(b, $urandom_range(8, 5));
        end
        n = 0;
        while (tx_q.size() != 0 && n < 400) begin
            tick(1);
            n++;
        end
        if (n >= 400) begin
            fails++;
            stop_test();
        end
        tick(6);
        cmp("tx flag drained", 8'h00, {6'h00, 1'(tx_q.size() != 0), txf_n});
        $display("write test done");

        // suspend with remote wakeup: flag pin turns input, long lows ask for resume
        usb_suspend_i = 1'b1;
        cfg_rw = 1'b1;
        tick(4);
        cmp("suspend pins", 8'h0d, {4'h0, power_enable_n_n, rxf_oe_n, pull_lo, pull_hi});
        wake_low = 1'b1;
        tick(8);
        wake_low = 1'b0;
        tick(6);
        cmp("resume after short low", 8'h00, 8'(resumes));
        wake_low = 1'b1;
        tick(WAKE + 8);
        wake_low = 1'b0;
        tick(6);
        cmp("resume after long low", 8'h01, 8'(resumes));
        cfg_rw = 1'b0;
        cfg_pl = 1'b1;
        tick(4);
        cmp("suspend pull low", 8'h0a, {4'h0, power_enable_n_n, rxf_oe_n, pull_lo, pull_hi});
        usb_suspend_i = 1'b0;
        tick(4);
        cmp("awake pulls", 8'h01, {4'h0, power_enable_n_n, rxf_oe_n, pull_lo, pull_hi});
        $display("suspend test done");
        stop_test();
    end
endmodule
